// >>> src/masr_status_regs.sv
// motor algorithm status bank behind an axi4-lite slave, read-only except the interrupt enable and clear registers
//
// How it works
// RL1 - speed detection phase code in low half, upper half reads zero
// RL2 - speed found during speed detection published as one word
// RL3 - position detection step code 0h..Ch in low half
// RL4 - initial rotor position angle published as one word
// RL5 - direct-axis back-emf estimate published as one word
// RL6 - quadrature-axis back-emf estimate published as one word
// RL7 - estimated rotor speed published as one word
// RL8 - estimated electrical rotor angle published as one word
// RL9 - every status word is zero after reset
// RL10 - host writes to the status words are ignored
// RL11 - each word is replaced whole in a single edge
//
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
module masr_status_regs (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [masr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [masr_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [masr_pkg::STRB_W-1:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [masr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [masr_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic SPD_PHASE_WE,
    input wire logic [masr_pkg::PHASE_W-1:0] SPD_PHASE_IN,
    input wire logic SPD_VALUE_WE,
    input wire logic [masr_pkg::DATA_W-1:0] SPD_VALUE_IN,
    input wire logic POS_PHASE_WE,
    input wire logic [masr_pkg::PHASE_W-1:0] POS_PHASE_IN,
    input wire logic POS_ANGLE_WE,
    input wire logic [masr_pkg::DATA_W-1:0] POS_ANGLE_IN,
    input wire logic EMF_D_WE,
    input wire logic [masr_pkg::DATA_W-1:0] EMF_D_IN,
    input wire logic EMF_Q_WE,
    input wire logic [masr_pkg::DATA_W-1:0] EMF_Q_IN,
    input wire logic ROT_SPEED_WE,
    input wire logic [masr_pkg::DATA_W-1:0] ROT_SPEED_IN,
    input wire logic ROT_ANGLE_WE,
    input wire logic [masr_pkg::DATA_W-1:0] ROT_ANGLE_IN,
    output logic IRQ
);
    localparam int VAL_N = masr_pkg::VAL_N;
    localparam int DATA_W = masr_pkg::DATA_W;
    localparam int PHASE_W = masr_pkg::PHASE_W;
    localparam int EVT_W = masr_pkg::EVT_W;
    localparam int PAD_W = DATA_W - PHASE_W;
    localparam int PAD_E = DATA_W - EVT_W;

    // byte address of a register index
    function automatic logic [masr_pkg::ADDR_W-1:0] byte_addr(
        input logic [masr_pkg::IDX_W-1:0] idx
    );
        return masr_pkg::ADDR_W'({idx, masr_pkg::LANE_ZERO});
    endfunction : byte_addr

    // a phase code is kept only if it is one the sequence can take
    function automatic logic code_ok(
        input logic [PHASE_W-1:0] code,
        input logic [PHASE_W-1:0] last
    );
        return code <= last;
    endfunction : code_ok

    // bus side
    logic wr_fire;
    logic [masr_pkg::ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [masr_pkg::STRB_W-1:0] wr_strb;
    logic [1:0] wr_resp;
    logic [masr_pkg::ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic [1:0] rd_resp;

    // stored state
    logic [PHASE_W-1:0] spd_phase_reg;
    logic [PHASE_W-1:0] spd_phase_next;
    logic [PHASE_W-1:0] pos_phase_reg;
    logic [PHASE_W-1:0] pos_phase_next;
    logic [DATA_W-1:0] val_reg [VAL_N];
    logic [DATA_W-1:0] val_in [VAL_N];
    logic [VAL_N-1:0] val_we;

    // phase update strobes and events
    logic spd_take;
    logic pos_take;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_enable;

    // read decode
    logic rh_spd_phase;
    logic rh_spd_value;
    logic rh_pos_phase;
    logic rh_pos_angle;
    logic rh_emf_d;
    logic rh_emf_q;
    logic rh_rot_speed;
    logic rh_rot_angle;
    logic rh_irq_status;
    logic rh_irq_enable;
    logic rh_irq_clear;
    logic rd_mapped;

    // write decode
    logic wh_status_bank;
    logic wh_irq_status;
    logic wh_irq_enable;
    logic wh_irq_clear;
    logic clr_we;
    logic en_we;

    masr_axil_slave u_bus (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr_fire(wr_fire),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_resp(wr_resp),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_resp(rd_resp)
    );

    // phase words: illegal codes dropped so software never sees them
    assign spd_take = SPD_PHASE_WE
        && code_ok(SPD_PHASE_IN, masr_pkg::SPD_FAULT); // RL1
    assign pos_take = POS_PHASE_WE
        && code_ok(POS_PHASE_IN, masr_pkg::POS_FAULT); // RL3
    assign spd_phase_next = spd_take ? SPD_PHASE_IN : spd_phase_reg;
    assign pos_phase_next = pos_take ? POS_PHASE_IN : pos_phase_reg;

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            spd_phase_reg <= masr_pkg::PHASE_RESET; // RL9
            pos_phase_reg <= masr_pkg::PHASE_RESET; // RL9
        end else begin
            spd_phase_reg <= spd_phase_next;
            pos_phase_reg <= pos_phase_next;
        end
    end

    // estimate words, only the algorithm side can load them
    assign val_we = {
        ROT_ANGLE_WE,
        ROT_SPEED_WE,
        EMF_Q_WE,
        EMF_D_WE,
        POS_ANGLE_WE,
        SPD_VALUE_WE
    };
    assign val_in[0] = SPD_VALUE_IN; // RL2
    assign val_in[1] = POS_ANGLE_IN; // RL4
    assign val_in[2] = EMF_D_IN; // RL5
    assign val_in[3] = EMF_Q_IN; // RL6
    assign val_in[4] = ROT_SPEED_IN; // RL7
    assign val_in[5] = ROT_ANGLE_IN; // RL8

    for (genvar g = 0; g < VAL_N; g++) begin : g_val
        always_ff @(posedge CORE_CLK) begin
            if (!RESET_N) begin
                val_reg[g] <= masr_pkg::RESET_WORD; // RL9
            end else if (val_we[g]) begin
                val_reg[g] <= val_in[g]; // RL11
            end
        end
    end

    // completion and fault of either detection raise an event
    assign evt_set[masr_pkg::EVT_SPD_DONE] =
        spd_take && (SPD_PHASE_IN == masr_pkg::SPD_COMPLETE);
    assign evt_set[masr_pkg::EVT_SPD_FAIL] =
        spd_take && (SPD_PHASE_IN == masr_pkg::SPD_FAULT);
    assign evt_set[masr_pkg::EVT_POS_DONE] =
        pos_take && (POS_PHASE_IN == masr_pkg::POS_COMPLETE);
    assign evt_set[masr_pkg::EVT_POS_FAIL] =
        pos_take && (POS_PHASE_IN == masr_pkg::POS_FAULT);

    // read address decode
    assign rh_spd_phase = rd_addr == byte_addr(masr_pkg::IDX_SPD_PHASE);
    assign rh_spd_value = rd_addr == byte_addr(masr_pkg::IDX_SPD_VALUE);
    assign rh_pos_phase = rd_addr == byte_addr(masr_pkg::IDX_POS_PHASE);
    assign rh_pos_angle = rd_addr == byte_addr(masr_pkg::IDX_POS_ANGLE);
    assign rh_emf_d = rd_addr == byte_addr(masr_pkg::IDX_EMF_D);
    assign rh_emf_q = rd_addr == byte_addr(masr_pkg::IDX_EMF_Q);
    assign rh_rot_speed = rd_addr == byte_addr(masr_pkg::IDX_ROT_SPEED);
    assign rh_rot_angle = rd_addr == byte_addr(masr_pkg::IDX_ROT_ANGLE);
    assign rh_irq_status = rd_addr == byte_addr(masr_pkg::IDX_IRQ_STATUS);
    assign rh_irq_enable = rd_addr == byte_addr(masr_pkg::IDX_IRQ_ENABLE);
    assign rh_irq_clear = rd_addr == byte_addr(masr_pkg::IDX_IRQ_CLEAR);
    assign rd_mapped = rh_spd_phase || rh_spd_value || rh_pos_phase
        || rh_pos_angle || rh_emf_d || rh_emf_q || rh_rot_speed
        || rh_rot_angle || rh_irq_status || rh_irq_enable
        || rh_irq_clear;

    // clear register is write-only and reads zero, but answers OKAY where unmapped space answers DECERR
    assign rd_data =
        ({DATA_W{rh_spd_phase}}
            & {{PAD_W{1'b0}}, spd_phase_reg}) // RL1
        | ({DATA_W{rh_spd_value}} & val_reg[0]) // RL2
        | ({DATA_W{rh_pos_phase}}
            & {{PAD_W{1'b0}}, pos_phase_reg}) // RL3
        | ({DATA_W{rh_pos_angle}} & val_reg[1]) // RL4
        | ({DATA_W{rh_emf_d}} & val_reg[2]) // RL5
        | ({DATA_W{rh_emf_q}} & val_reg[3]) // RL6
        | ({DATA_W{rh_rot_speed}} & val_reg[4]) // RL7
        | ({DATA_W{rh_rot_angle}} & val_reg[5]) // RL8
        | ({DATA_W{rh_irq_status}} & {{PAD_E{1'b0}}, irq_status})
        | ({DATA_W{rh_irq_enable}} & {{PAD_E{1'b0}}, irq_enable});
    assign rd_resp = rd_mapped ? masr_pkg::RESP_OKAY
        : masr_pkg::RESP_DECERR;

    // write address decode
    assign wh_status_bank =
        (wr_addr == byte_addr(masr_pkg::IDX_SPD_PHASE))
        || (wr_addr == byte_addr(masr_pkg::IDX_SPD_VALUE))
        || (wr_addr == byte_addr(masr_pkg::IDX_POS_PHASE))
        || (wr_addr == byte_addr(masr_pkg::IDX_POS_ANGLE))
        || (wr_addr == byte_addr(masr_pkg::IDX_EMF_D))
        || (wr_addr == byte_addr(masr_pkg::IDX_EMF_Q))
        || (wr_addr == byte_addr(masr_pkg::IDX_ROT_SPEED))
        || (wr_addr == byte_addr(masr_pkg::IDX_ROT_ANGLE));
    assign wh_irq_status = wr_addr == byte_addr(masr_pkg::IDX_IRQ_STATUS);
    assign wh_irq_enable = wr_addr == byte_addr(masr_pkg::IDX_IRQ_ENABLE);
    assign wh_irq_clear = wr_addr == byte_addr(masr_pkg::IDX_IRQ_CLEAR);

    // status words have no write path at all; the bus only learns why
    assign wr_resp = (wh_irq_enable || wh_irq_clear)
        ? masr_pkg::RESP_OKAY
        : (wh_status_bank || wh_irq_status) ? masr_pkg::RESP_SLVERR // RL10
        : masr_pkg::RESP_DECERR;

    // event fields sit in byte lane zero
    assign en_we = wr_fire && wh_irq_enable && wr_strb[0];
    assign clr_we = wr_fire && wh_irq_clear && wr_strb[0];

    masr_irq #(
        .N(EVT_W)
    ) u_irq (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .evt_set(evt_set),
        .clr_we(clr_we),
        .clr_mask(wr_data[EVT_W-1:0]),
        .en_we(en_we),
        .en_data(wr_data[EVT_W-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(IRQ)
    );
endmodule : masr_status_regs
`default_nettype wire

// >>> common/masr_pkg.sv
// constants shared by the motor algorithm status register bank
`default_nettype none
package masr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int IDX_W = 12;
    localparam int PHASE_W = 16;
    localparam int EVT_W = 4;
    localparam int VAL_N = 6;
    // fixed-point scale of every estimate word
    localparam int FRAC_BITS = 27;
    localparam logic [1:0] LANE_ZERO = 2'h0;
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SPD_PHASE = 12'h67A;
    localparam logic [IDX_W-1:0] IDX_SPD_VALUE = 12'h684;
    localparam logic [IDX_W-1:0] IDX_POS_PHASE = 12'h6B8;
    localparam logic [IDX_W-1:0] IDX_POS_ANGLE = 12'h6FC;
    localparam logic [IDX_W-1:0] IDX_EMF_D = 12'h742;
    localparam logic [IDX_W-1:0] IDX_EMF_Q = 12'h744;
    localparam logic [IDX_W-1:0] IDX_ROT_SPEED = 12'h752;
    localparam logic [IDX_W-1:0] IDX_ROT_ANGLE = 12'h756;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h780;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 12'h781;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 12'h782;
    localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 16'h0000;
    localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
    // speed detection phase codes
    localparam logic [PHASE_W-1:0] SPD_INIT = 16'h0000;
    localparam logic [PHASE_W-1:0] SPD_STOP_CHECK = 16'h0001;
    localparam logic [PHASE_W-1:0] SPD_DIR_CHECK = 16'h0002;
    localparam logic [PHASE_W-1:0] SPD_COMPLETE = 16'h0003;
    localparam logic [PHASE_W-1:0] SPD_FAULT = 16'h0004;
    // position detection phase codes, 0h through Ch in sequence
    localparam logic [PHASE_W-1:0] POS_INIT = 16'h0000;
    localparam logic [PHASE_W-1:0] POS_COMPLETE = 16'h000B;
    localparam logic [PHASE_W-1:0] POS_FAULT = 16'h000C;
    // interrupt event bit positions
    localparam int EVT_SPD_DONE = 0;
    localparam int EVT_SPD_FAIL = 1;
    localparam int EVT_POS_DONE = 2;
    localparam int EVT_POS_FAIL = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : masr_pkg
`default_nettype wire

// >>> src/masr_axil_slave.sv
// axi4-lite slave front end turning bus transfers into single-cycle requests
`default_nettype none
module masr_axil_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [masr_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [masr_pkg::DATA_W-1:0] wdata,
    input wire logic [masr_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [masr_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [masr_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_fire,
    output logic [masr_pkg::ADDR_W-1:0] wr_addr,
    output logic [masr_pkg::DATA_W-1:0] wr_data,
    output logic [masr_pkg::STRB_W-1:0] wr_strb,
    input wire logic [1:0] wr_resp,
    output logic [masr_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [masr_pkg::DATA_W-1:0] rd_data,
    input wire logic [1:0] rd_resp
);
    logic aw_held_reg;
    logic w_held_reg;
    logic [masr_pkg::ADDR_W-1:0] aw_addr_reg;
    logic [masr_pkg::DATA_W-1:0] w_data_reg;
    logic [masr_pkg::STRB_W-1:0] w_strb_reg;
    logic aw_take;
    logic w_take;
    logic ar_take;

    assign awready = !aw_held_reg;
    assign wready = !w_held_reg;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    // one write in flight: fire only once the previous response is gone
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
    assign wr_addr = aw_addr_reg;
    assign wr_data = w_data_reg;
    assign wr_strb = w_strb_reg;
    assign arready = !rvalid;
    assign ar_take = arvalid && arready;
    assign rd_addr = araddr;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid <= 1'b0;
            bresp <= masr_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= wr_resp;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read data captured whole in one edge, never half old, half new
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= masr_pkg::RESET_WORD;
            rresp <= masr_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_resp;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : masr_axil_slave
`default_nettype wire

// >>> src/masr_irq.sv
// sticky event status with enable mask and one level interrupt
`default_nettype none
module masr_irq #(
    parameter int N = masr_pkg::EVT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] evt_set,
    input wire logic clr_we,
    input wire logic [N-1:0] clr_mask,
    input wire logic en_we,
    input wire logic [N-1:0] en_data,
    output logic [N-1:0] status,
    output logic [N-1:0] enable,
    output logic irq
);
    logic [N-1:0] status_next;

    // a new event in the clearing cycle survives the clear
    assign status_next = (status & ~(clr_we ? clr_mask : '0)) | evt_set;
    assign irq = |(status & enable);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= '0;
            enable <= '0;
        end else begin
            status <= status_next;
            if (en_we) begin
                enable <= en_data;
            end
        end
    end
endmodule : masr_irq
`default_nettype wire

// >>> tb/masr_status_regs_sva.sv
// concurrent checks on the status bank's bus and interrupt ports
`default_nettype none
module masr_status_regs_sva (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [masr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [masr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [masr_pkg::DATA_W-1:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic IRQ
);
    localparam logic [15:0] A_SPD = {2'h0, masr_pkg::IDX_SPD_PHASE, 2'h0};
    localparam logic [15:0] A_POS = {2'h0, masr_pkg::IDX_POS_PHASE, 2'h0};
    localparam logic [15:0] A_EMF = {2'h0, masr_pkg::IDX_EMF_D, 2'h0};
    // addresses held so responses can be tied to what was asked
    logic [15:0] ra_reg;
    logic [15:0] wa_reg;
    always_ff @(posedge CORE_CLK) begin
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            ra_reg <= S_AXI_ARADDR;
        end
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            wa_reg <= S_AXI_AWADDR;
        end
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence s_ar_take;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence s_wr_pair;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            && !S_AXI_BVALID;
    endsequence
    a_rd_answer: assert property (s_ar_take |=> S_AXI_RVALID)
        else $error("read answer late");
    a_wr_answer: assert property (s_wr_pair |-> ##2 S_AXI_BVALID)
        else $error("write answer late");
    a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
        && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
        else $error("read answer not held");
    a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer not held");
    a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address taken while answer pending");
    a_phase_high: assert property (S_AXI_RVALID && (ra_reg == A_SPD
        || ra_reg == A_POS) |-> S_AXI_RDATA[31:16] == 16'h0000)
        else $error("phase upper half not zero");
    a_ro_refused: assert property ($rose(S_AXI_BVALID) && (wa_reg == A_EMF
        || wa_reg == A_SPD) |-> S_AXI_BRESP == masr_pkg::RESP_SLVERR)
        else $error("status word write not refused");
    a_misaligned: assert property (S_AXI_RVALID && ra_reg[1:0] != 2'h0 |->
        S_AXI_RRESP == masr_pkg::RESP_DECERR && S_AXI_RDATA == 32'h00000000)
        else $error("misaligned read not refused");
    a_reset_quiet: assert property ($rose(RESET_N) |-> !S_AXI_RVALID
        && !S_AXI_BVALID && !IRQ && S_AXI_ARREADY)
        else $error("outputs busy after reset");
endmodule : masr_status_regs_sva
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the motor algorithm status bank
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OKR = masr_pkg::RESP_OKAY;
    localparam logic [1:0] SLV = masr_pkg::RESP_SLVERR;
    localparam logic [1:0] DEC = masr_pkg::RESP_DECERR;
    localparam logic [15:0] A_ST = {2'h0, masr_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [15:0] A_EN = {2'h0, masr_pkg::IDX_IRQ_ENABLE, 2'h0};
    localparam logic [15:0] A_CLR = {2'h0, masr_pkg::IDX_IRQ_CLEAR, 2'h0};
    localparam logic [11:0] IDX_TBL [8] = '{masr_pkg::IDX_SPD_PHASE,
        masr_pkg::IDX_SPD_VALUE, masr_pkg::IDX_POS_PHASE,
        masr_pkg::IDX_POS_ANGLE, masr_pkg::IDX_EMF_D, masr_pkg::IDX_EMF_Q,
        masr_pkg::IDX_ROT_SPEED, masr_pkg::IDX_ROT_ANGLE};
    logic clk;
    logic rst_n;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [1:0] bresp, rresp;
    logic [7:0] we;
    logic [31:0] val [8];
    logic [31:0] exp_w [8];
    int bad_count;
    int checked;
    int k;
    masr_status_regs i_dut (
        .CORE_CLK(clk), .RESET_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .SPD_PHASE_WE(we[0]), .SPD_PHASE_IN(val[0][15:0]),
        .SPD_VALUE_WE(we[1]), .SPD_VALUE_IN(val[1]),
        .POS_PHASE_WE(we[2]), .POS_PHASE_IN(val[2][15:0]),
        .POS_ANGLE_WE(we[3]), .POS_ANGLE_IN(val[3]),
        .EMF_D_WE(we[4]), .EMF_D_IN(val[4]),
        .EMF_Q_WE(we[5]), .EMF_Q_IN(val[5]),
        .ROT_SPEED_WE(we[6]), .ROT_SPEED_IN(val[6]),
        .ROT_ANGLE_WE(we[7]), .ROT_ANGLE_IN(val[7]),
        .IRQ(irq)
    );
    function automatic logic [15:0] adr(input int i);
        return {2'h0, IDX_TBL[i], 2'h0};
    endfunction : adr
    task automatic conclude();
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_word
    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
        cmp_word({30'h0, g}, {30'h0, e});
    endtask : cmp_resp
    task automatic cmp_bit(input logic g, input logic e);
        cmp_word({31'h0, g}, {31'h0, e});
    endtask : cmp_bit
    // ready goes up with the request and stays until the answer is seen
    task automatic rd(input logic [15:0] a, input logic [31:0] e,
        input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 40);
        rready <= 1'b0;
        if (n >= 40) begin
            bad_count++;
            conclude();
        end else begin
            cmp_word(rdata, e);
            cmp_resp(rresp, er);
        end
        @(posedge clk);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 40);
        bready <= 1'b0;
        if (n >= 40) begin
            bad_count++;
            conclude();
        end else begin
            cmp_resp(bresp, er);
        end
        @(posedge clk);
    endtask : wr
    task automatic load(input int i, input logic [31:0] d);
        val[i] <= d;
        we[i] <= 1'b1;
        @(posedge clk);
        we[i] <= 1'b0;
    endtask : load
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        {awaddr, araddr, wdata, we} = 72'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        wstrb = 4'hF;
        bad_count = 0;
        checked = 0;
        foreach (val[i]) val[i] = 32'h00000000;
        foreach (exp_w[i]) exp_w[i] = 32'h00000000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cmp_bit(irq, 1'b0);
        for (k = 0; k < 8; k++) rd(adr(k), 32'h00000000, OKR);
        // loads go back to back; the second must land whole
        for (k = 1; k < 8; k++) begin
            v = 32'h80000001 ^ {8{k[3:0]}};
            if (k != 2) begin
                // strobe stays up across both words
                val[k] <= ~v;
                we[k] <= 1'b1;
                @(posedge clk);
                load(k, v);
                @(posedge clk);
                rd(adr(k), v, OKR);
                exp_w[k] = v;
            end
        end
        for (k = 0; k < 6; k++) begin
            load(0, {16'hFFFF, k[15:0]});
            @(posedge clk);
            rd(adr(0), (k < 5) ? k : 32'h00000004, OKR);
        end
        for (k = 0; k < 14; k++) begin
            load(2, {16'hFFFF, k[15:0]});
            @(posedge clk);
            rd(adr(2), (k < 13) ? k : 32'h0000000C, OKR);
        end
        exp_w[0] = 32'h00000004;
        exp_w[2] = 32'h0000000C;
        rd(A_ST, 32'h0000000F, OKR);
        cmp_bit(irq, 1'b0);
        wr(A_EN, 32'h00000004, OKR);
        rd(A_EN, 32'h00000004, OKR);
        cmp_bit(irq, 1'b1);
        wr(A_CLR, 32'h00000004, OKR);
        cmp_bit(irq, 1'b0);
        wr(A_ST, 32'hFFFFFFFF, SLV);
        rd(A_ST, 32'h0000000B, OKR);
        wr(A_EN, 32'h0000000F, OKR);
        cmp_bit(irq, 1'b1);
        wr(A_CLR, 32'h0000000F, OKR);
        cmp_bit(irq, 1'b0);
        for (k = 0; k < 8; k++) begin
            wr(adr(k), 32'hFFFFFFFF, SLV);
            rd(adr(k), exp_w[k], OKR);
        end
        rd(16'h0004, 32'h00000000, DEC);
        rd(A_EN + 16'h0001, 32'h00000000, DEC);
        wr(16'h0004, 32'h0000000F, DEC);
        conclude();
    end
endmodule : tb
bind masr_status_regs masr_status_regs_sva i_sva (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ)
);
`default_nettype wire
